// File: core/srvcc_pkg.sv
// Function
// (R1) Control bit 0 turns all virtual functions of a physical function on or off, resets to zero.
// (R2) Control bit 1 enables migration support, resets to zero, writable only when migration is supported.
// (R3) Control bit 2 enables the migration state change interrupt, resets to zero.
// (R4) Control bit 3 lets virtual functions decode memory; while clear they take no memory access.
// (R5) Control bit 4 lets virtual functions sit at function numbers 8 to 255; it resets to zero.
// (R6) Control bit 4 is writable only in the lowest physical function and reads zero elsewhere.
// (R7) A root-complex integrated endpoint hardwires control bit 4 to zero.
// (R8) Control bits 15 to 5 are reserved, hold no function and read back zero.
// (R9) The control register decodes at configuration offset 208h, dword aligned.
// (R10) Host software writes the active virtual-function count before turning virtual functions on.
// (R11) While control bit 0 is one, writes to the active virtual-function count are ignored.
// (R12) The active virtual-function count reads in bits 15:0 of the dword at offset 84h.
// (R13) Host software sets control bits 0 and 3 before sending memory requests to virtual functions.
// (R14) The alternative routing-id parameter is on, so extended function numbers are reachable.
// (R15) While control bit 0 is set, the virtual functions answer requests like ordinary endpoints.
// (R16) While control bit 0 is clear, no request to a virtual function of that function is answered.
// (R17) Configuration writes update only the bytes whose byte enables are set.
package srvcc_pkg;

	// ------------------------------------------------------------
	// function layout
	// ------------------------------------------------------------
	localparam int NUM_PF = 2;
	localparam logic [7:0] PF_FN_LIMIT = 8'h02;
	localparam logic [7:0] VF_FIRST_FN = 8'h02;
	localparam logic [7:0] VF_SLOTS_PER_PF = 8'h04;
	localparam logic [7:0] EXT_FN_START = 8'h08;

	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_ACTIVE_VF_COUNT = 12'h084;
	localparam logic [11:0] ADDR_VF_CONTROL = 12'h208;
	localparam int CTRL_ACTIVATE_BIT = 0;
	localparam int CTRL_MIGRATION_BIT = 1;
	localparam int CTRL_MIG_IRQ_BIT = 2;
	localparam int CTRL_MEM_DECODE_BIT = 3;
	localparam int CTRL_EXT_FN_BIT = 4;
	localparam int CTRL_IMPL_W = 5;
	localparam logic [CTRL_IMPL_W-1:0] CTRL_RESET = 5'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] fn;
		logic [9:0] dw;
		logic [3:0] be;
		logic [31:0] data;
	} srvcc_cfg_req_type;

	typedef struct packed {
		logic valid;
		logic [7:0] fn;
	} srvcc_mem_req_type;

	typedef struct packed {
		logic hit;
		logic [0:0] pf;
		logic [7:0] idx;
	} srvcc_vf_hit_type;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [9:0] dw_of(input logic [11:0] addr);
		dw_of = addr[11:2];
	endfunction

	// byte-enable merge of a 16-bit field in the low half
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] wdata, input logic [1:0] be);
		merge16 = old;
		if (be[0]) begin
			merge16[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			merge16[15:8] = wdata[15:8];
		end
	endfunction

	// map a function number onto its owning physical function
	function automatic srvcc_vf_hit_type decode_vf(input logic [7:0] fn,
		input logic ext_on);
		logic [7:0] rel;
		logic [7:0] lo;
		decode_vf = '0;
		rel = fn - VF_FIRST_FN;
		for (int p = 0; p < NUM_PF; p++) begin
			lo = 8'(p * 4);
			if (fn >= VF_FIRST_FN && rel >= lo &&
				rel < lo + VF_SLOTS_PER_PF &&
				(fn < EXT_FN_START || ext_on)) begin
				decode_vf.hit = 1'b1;
				decode_vf.pf = 1'(p);
				decode_vf.idx = rel - lo;
			end
		end
	endfunction

endpackage

// File: core/srvcc_top.sv
`timescale 1ns/1ps
module srvcc_top #(
	parameter bit MIGRATION_CAPABLE = 1'b0,
	parameter bit IS_RC_INTEGRATED = 1'b0,
	parameter bit ALT_ROUTING_ID_PARAM = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire srvcc_pkg::srvcc_cfg_req_type i_cfg_req,
	input wire srvcc_pkg::srvcc_mem_req_type i_mem_req,
	output logic o_cpl_valid,
	output logic [31:0] o_cpl_data,
	output logic o_req_dropped,
	output logic o_mem_accept,
	output logic [srvcc_pkg::NUM_PF-1:0] o_vf_active,
	output logic [srvcc_pkg::NUM_PF-1:0] o_vf_mem_on,
	output logic [srvcc_pkg::NUM_PF-1:0] o_migration_on,
	output logic [srvcc_pkg::NUM_PF-1:0] o_migration_irq_on,
	output logic o_ext_fn_on
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [srvcc_pkg::CTRL_IMPL_W-1:0] ctrl_r [srvcc_pkg::NUM_PF];
	logic [srvcc_pkg::CTRL_IMPL_W-1:0] ctrl_nxt [srvcc_pkg::NUM_PF];
	logic [15:0] count_r [srvcc_pkg::NUM_PF];
	logic [15:0] count_nxt [srvcc_pkg::NUM_PF];
	logic cpl_valid_r;
	logic cpl_valid_nxt;
	logic [31:0] cpl_data_r;
	logic [31:0] cpl_data_nxt;
	logic dropped_r;
	logic dropped_nxt;
	logic mem_accept_r;
	logic mem_accept_nxt;
	logic ext_on;
	srvcc_pkg::srvcc_vf_hit_type cfg_vf;
	srvcc_pkg::srvcc_vf_hit_type mem_vf;

	// local copy of the stored control width, declared before its users
	localparam int CTRL_W_LOCAL = srvcc_pkg::CTRL_IMPL_W;

	logic [CTRL_W_LOCAL-1:0] wmask [srvcc_pkg::NUM_PF];

	// ------------------------------------------------------------
	// writable bits per physical function
	// ------------------------------------------------------------
	// migration bit follows capability; extension bit only in the
	// lowest function, never in an integrated endpoint
	always_comb begin
		for (int p = 0; p < srvcc_pkg::NUM_PF; p++) begin
			wmask[p] = '0;
			wmask[p][srvcc_pkg::CTRL_ACTIVATE_BIT] = 1'b1; // R1
			wmask[p][srvcc_pkg::CTRL_MIGRATION_BIT] = MIGRATION_CAPABLE; // R2
			wmask[p][srvcc_pkg::CTRL_MIG_IRQ_BIT] = 1'b1; // R3
			wmask[p][srvcc_pkg::CTRL_MEM_DECODE_BIT] = 1'b1; // R4
			wmask[p][srvcc_pkg::CTRL_EXT_FN_BIT] = (p == 0) &&
				!IS_RC_INTEGRATED && ALT_ROUTING_ID_PARAM; // R6 R7 R14
		end
	end

	// ------------------------------------------------------------
	// function decode
	// ------------------------------------------------------------
	// extended numbering is governed by the lowest function only
	assign ext_on = ctrl_r[0][srvcc_pkg::CTRL_EXT_FN_BIT]; // R5
	assign cfg_vf = srvcc_pkg::decode_vf(i_cfg_req.fn, ext_on);
	assign mem_vf = srvcc_pkg::decode_vf(i_mem_req.fn, ext_on);

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_comb begin
		logic [15:0] merged;
		merged = '0;
		for (int p = 0; p < srvcc_pkg::NUM_PF; p++) begin
			ctrl_nxt[p] = ctrl_r[p];
			count_nxt[p] = count_r[p];
			if (i_cfg_req.valid && i_cfg_req.write &&
				i_cfg_req.fn == 8'(p)) begin
				if (i_cfg_req.dw ==
					srvcc_pkg::dw_of(srvcc_pkg::ADDR_VF_CONTROL)) begin // R9
					merged = srvcc_pkg::merge16({11'h000, ctrl_r[p]},
						i_cfg_req.data[15:0], i_cfg_req.be[1:0]); // R17
					// reserved bits 15:5 are simply not stored
					ctrl_nxt[p] = (merged[CTRL_W_LOCAL-1:0] & wmask[p]) |
						(ctrl_r[p] & ~wmask[p]); // R8
				end
				if (i_cfg_req.dw ==
					srvcc_pkg::dw_of(srvcc_pkg::ADDR_ACTIVE_VF_COUNT) &&
					!ctrl_r[p][srvcc_pkg::CTRL_ACTIVATE_BIT]) begin // R11
					count_nxt[p] = srvcc_pkg::merge16(count_r[p],
						i_cfg_req.data[15:0], i_cfg_req.be[1:0]); // R17
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int p = 0; p < srvcc_pkg::NUM_PF; p++) begin
				ctrl_r[p] <= srvcc_pkg::CTRL_RESET; // R1 R2 R3 R4 R5
				count_r[p] <= srvcc_pkg::COUNT_RESET;
			end
		end else begin
			for (int p = 0; p < srvcc_pkg::NUM_PF; p++) begin
				ctrl_r[p] <= ctrl_nxt[p];
				count_r[p] <= count_nxt[p];
			end
		end
	end

	// ------------------------------------------------------------
	// configuration completions
	// ------------------------------------------------------------
	// physical functions always answer; a virtual function answers
	// only while its owner has it switched on and in range
	always_comb begin
		logic vf_live;
		vf_live = cfg_vf.hit &&
			ctrl_r[cfg_vf.pf][srvcc_pkg::CTRL_ACTIVATE_BIT] &&
			{8'h00, cfg_vf.idx} < count_r[cfg_vf.pf];
		cpl_valid_nxt = 1'b0;
		cpl_data_nxt = srvcc_pkg::READ_ZERO;
		dropped_nxt = 1'b0;
		if (i_cfg_req.valid) begin
			if (i_cfg_req.fn < srvcc_pkg::PF_FN_LIMIT) begin
				cpl_valid_nxt = 1'b1;
				if (!i_cfg_req.write && i_cfg_req.dw ==
					srvcc_pkg::dw_of(srvcc_pkg::ADDR_VF_CONTROL)) begin // R9
					cpl_data_nxt = {27'h0000000,
						ctrl_r[i_cfg_req.fn[0]]}; // R8
				end
				if (!i_cfg_req.write && i_cfg_req.dw ==
					srvcc_pkg::dw_of(srvcc_pkg::ADDR_ACTIVE_VF_COUNT)) begin
					cpl_data_nxt = {16'h0000,
						count_r[i_cfg_req.fn[0]]}; // R12
				end
			end else if (vf_live) begin
				cpl_valid_nxt = 1'b1; // R15
			end else begin
				dropped_nxt = 1'b1; // R16
			end
		end
	end

	// ------------------------------------------------------------
	// memory acceptance for virtual functions
	// ------------------------------------------------------------
	always_comb begin
		mem_accept_nxt = i_mem_req.valid && mem_vf.hit &&
			ctrl_r[mem_vf.pf][srvcc_pkg::CTRL_ACTIVATE_BIT] && // R16
			ctrl_r[mem_vf.pf][srvcc_pkg::CTRL_MEM_DECODE_BIT] && // R4
			{8'h00, mem_vf.idx} < count_r[mem_vf.pf]; // R15
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cpl_valid_r <= 1'b0;
			cpl_data_r <= srvcc_pkg::READ_ZERO;
			dropped_r <= 1'b0;
			mem_accept_r <= 1'b0;
		end else begin
			cpl_valid_r <= cpl_valid_nxt;
			cpl_data_r <= cpl_data_nxt;
			dropped_r <= dropped_nxt;
			mem_accept_r <= mem_accept_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs, all straight from flops
	// ------------------------------------------------------------
	always_comb begin
		for (int p = 0; p < srvcc_pkg::NUM_PF; p++) begin
			o_vf_active[p] = ctrl_r[p][srvcc_pkg::CTRL_ACTIVATE_BIT];
			o_vf_mem_on[p] = ctrl_r[p][srvcc_pkg::CTRL_MEM_DECODE_BIT];
			o_migration_on[p] = ctrl_r[p][srvcc_pkg::CTRL_MIGRATION_BIT];
			o_migration_irq_on[p] = ctrl_r[p][srvcc_pkg::CTRL_MIG_IRQ_BIT];
		end
	end

	assign o_ext_fn_on = ext_on;
	assign o_cpl_valid = cpl_valid_r;
	assign o_cpl_data = cpl_data_r;
	assign o_req_dropped = dropped_r;
	assign o_mem_accept = mem_accept_r;

endmodule

// File: testbench/srvcc_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module srvcc_monitor (
	input wire logic i_core_clk,
	input wire logic i_resetn,
	input wire srvcc_pkg::srvcc_cfg_req_type i_cfg_req,
	input wire srvcc_pkg::srvcc_mem_req_type i_mem_req,
	input wire logic o_cpl_valid,
	input wire logic [31:0] o_cpl_data,
	input wire logic o_req_dropped,
	input wire logic o_mem_accept,
	input wire logic [srvcc_pkg::NUM_PF-1:0] o_vf_active,
	input wire logic [srvcc_pkg::NUM_PF-1:0] o_vf_mem_on,
	input wire logic [srvcc_pkg::NUM_PF-1:0] o_migration_irq_on,
	input wire logic o_ext_fn_on
);
	// control-register write decode
	wire logic cs = i_cfg_req.valid && i_cfg_req.write && i_cfg_req.dw == 10'h082;
	wire logic cs0 = cs && i_cfg_req.fn == 8'h00;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_resetn);
	sequence s_rd_ctrl;
		i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.dw == 10'h082;
	endsequence
	property p_answer;
		i_cfg_req.valid |=> o_cpl_valid != o_req_dropped;
	endproperty
	a_answer: assert property (p_answer) else $error("answer count");
	property p_act;
		cs0 && i_cfg_req.be[0] |=> o_vf_active[0] == $past(i_cfg_req.data[0]);
	endproperty
	a_act: assert property (p_act) else $error("activate lost");
	property p_irq;
		cs && i_cfg_req.fn == 8'h01 && i_cfg_req.be[0]
			|=> o_migration_irq_on[1] == $past(i_cfg_req.data[2]);
	endproperty
	a_irq: assert property (p_irq) else $error("irq enable lost");
	property p_mem;
		o_mem_accept |-> $past(i_mem_req.valid && (o_vf_active & o_vf_mem_on) != 0);
	endproperty
	a_mem: assert property (p_mem) else $error("memory decode off");
	property p_ext;
		$changed(o_ext_fn_on) |-> $past(cs0 && i_cfg_req.be[0]);
	endproperty
	a_ext: assert property (p_ext) else $error("ext numbering moved");
	property p_rsv;
		s_rd_ctrl ##1 o_cpl_valid |-> o_cpl_data[31:5] == '0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_vf_off;
		i_cfg_req.valid && i_cfg_req.fn inside {[8'h02:8'h05]} && !o_vf_active[0]
			|=> o_req_dropped;
	endproperty
	a_vf_off: assert property (p_vf_off) else $error("off vf answered");
	property p_be;
		cs0 && !i_cfg_req.be[0] |=> $stable(o_vf_active[0]);
	endproperty
	a_be: assert property (p_be) else $error("disabled byte written");
endmodule

bind srvcc_top srvcc_monitor u_mon (.i_core_clk(i_core_clk),
	.i_resetn(i_resetn), .i_cfg_req(i_cfg_req), .i_mem_req(i_mem_req),
	.o_cpl_valid(o_cpl_valid), .o_cpl_data(o_cpl_data),
	.o_req_dropped(o_req_dropped), .o_mem_accept(o_mem_accept),
	.o_vf_active(o_vf_active), .o_vf_mem_on(o_vf_mem_on),
	.o_migration_irq_on(o_migration_irq_on), .o_ext_fn_on(o_ext_fn_on));

// File: testbench/srvcc_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host request source
// ------------------------------------------------------------
module srvcc_host_model (
	output srvcc_pkg::srvcc_cfg_req_type o_cfg,
	output srvcc_pkg::srvcc_mem_req_type o_mem
);
	// one cycle of requests; an idle configuration port shows turned-over fields
	task automatic issue(input srvcc_pkg::srvcc_cfg_req_type c,
		input srvcc_pkg::srvcc_mem_req_type m);
		if (!c.valid) begin
			c = ~o_cfg;
			c.valid = 1'b0;
		end
		o_cfg = c;
		o_mem = m;
	endtask
endmodule

// File: testbench/tb_sriov_capability_control.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
	$display("BAD %s exp %h got %h", nm, e, s); n_fail++; end end
module tb_sriov_capability_control;
	logic i_core_clk = 0;
	logic i_resetn = 0;
	srvcc_pkg::srvcc_cfg_req_type cfg;
	srvcc_pkg::srvcc_mem_req_type mem;
	logic o_cpl_valid, o_req_dropped, o_mem_accept, o_ext_fn_on;
	logic [31:0] o_cpl_data;
	logic [1:0] o_vf_active, o_vf_mem_on, o_migration_on, o_migration_irq_on;
	logic [15:0] ctrl [2];
	logic [15:0] cnt [2];
	logic e_cpl, e_drop, e_mem;
	logic [31:0] e_dat;
	int n_fail = 0;
	int checks_done = 0;
	int tbl [4] = '{'h21, 'h82, 'h82, 'h10};
	int msk [4] = '{'h7, -1, -1, -1};
	srvcc_host_model u_host (.o_cfg(cfg), .o_mem(mem));
	srvcc_top u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
		.i_cfg_req(cfg), .i_mem_req(mem), .o_cpl_valid(o_cpl_valid),
		.o_cpl_data(o_cpl_data), .o_req_dropped(o_req_dropped),
		.o_mem_accept(o_mem_accept), .o_vf_active(o_vf_active),
		.o_vf_mem_on(o_vf_mem_on), .o_migration_on(o_migration_on),
		.o_migration_irq_on(o_migration_irq_on), .o_ext_fn_on(o_ext_fn_on));
	// ------------------------------------------------------------
	// model and stimulus
	// ------------------------------------------------------------
	// check the last answer, predict this one, then drive it
	task automatic step(input int w, fn, dw, be, d, mv, mf);
		int p;
		logic [4:0] m;
		@(negedge i_core_clk);
		`CHK("cpl", e_cpl, o_cpl_valid)
		`CHK("drop", e_drop, o_req_dropped)
		`CHK("data", e_dat, o_cpl_data)
		`CHK("macc", e_mem, o_mem_accept)
		`CHK("act", {ctrl[1][0], ctrl[0][0]}, o_vf_active)
		`CHK("mse", {ctrl[1][3], ctrl[0][3]}, o_vf_mem_on)
		`CHK("mig", {ctrl[1][1], ctrl[0][1]}, o_migration_on)
		`CHK("irq", {ctrl[1][2], ctrl[0][2]}, o_migration_irq_on)
		`CHK("ext", ctrl[0][4], o_ext_fn_on)
		p = (mf - 2) / 4;
		e_mem = mv && mf >= 2 && (mf < 8 || ctrl[0][4]) && ctrl[p][0] &&
			ctrl[p][3] && (mf - 2) % 4 < cnt[p];
		e_dat = 0;
		e_cpl = 1;
		e_drop = 0;
		if (fn >= 2) begin
			p = (fn - 2) / 4;
			e_cpl = (fn < 8 || ctrl[0][4]) && ctrl[p][0] && (fn - 2) % 4 < cnt[p];
			e_drop = !e_cpl;
		end else if (!w) begin
			e_dat = dw == 'h21 ? cnt[fn] : dw == 'h82 ? ctrl[fn] : 0;
		end else if (dw == 'h82 && be[0]) begin
			m = fn ? 5'h0d : 5'h1d;
			ctrl[fn][4:0] = (ctrl[fn][4:0] & ~m) | (d[4:0] & m);
		end else if (dw == 'h21 && !ctrl[fn][0]) begin
			cnt[fn] = {be[1] ? d[15:8] : cnt[fn][15:8],
				be[0] ? d[7:0] : cnt[fn][7:0]};
		end
		u_host.issue('{1'b1, 1'(w), 8'(fn), 10'(dw), 4'(be), d}, '{1'(mv), 8'(mf)});
	endtask
	// reset with the request ports idle
	task automatic do_reset();
		@(negedge i_core_clk);
		i_resetn = 0;
		u_host.issue('0, '0);
		ctrl = '{default: 16'h0000};
		cnt = '{default: 16'h0000};
		{e_cpl, e_drop, e_mem, e_dat} = '0;
		repeat (3) @(negedge i_core_clk);
		`CHK("rst", 6'h00, {o_cpl_valid, o_vf_active, o_vf_mem_on, o_ext_fn_on})
		i_resetn = 1;
	endtask
	task automatic finish_test();
		if (n_fail == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// clock
	initial begin
		forever #2.5 i_core_clk = ~i_core_clk;
	end
	// directed walk, then random traffic with a reset in mid-run
	initial begin
		int k;
		void'($urandom(70831));
		u_host.issue('0, '0);
		do_reset();
		step(1, 0, 'h21, 3, 3, 0, 0);
		step(1, 0, 'h82, 1, 'h9, 0, 0);
		step(1, 0, 'h21, 3, 1, 1, 4);
		step(0, 0, 'h21, 3, 0, 1, 5);
		for (int i = 0; i < 4000; i++) begin
			if (i == 2000) begin
				do_reset();
			end
			k = $urandom % 4;
			step($urandom % 2, $urandom % 10, tbl[k], $urandom % 16,
				$urandom & msk[k], $urandom % 2, $urandom % 10);
		end
		step(0, 0, 0, 0, 0, 0, 0);
		finish_test();
	end
endmodule
